// [rtl/wpr_pkg.sv]
`default_nettype none
package wpr_pkg;

    // ------------------------------------------------------------
    // Sizes and bus
    // ------------------------------------------------------------
    localparam int WORD_W = 16;
    localparam int ADDR_W = 4;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_CTRL     = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_PAT_VAL  = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_PAT_CARE = 4'h8;
    localparam logic [ADDR_W-1:0] OFF_STATUS   = 4'hc;
    // Second page through bit 4 of the address is not used; extra
    // registers are placed at the upper half by index below.
    localparam logic [5:0] IDX_CTRL     = 6'h00;
    localparam logic [5:0] IDX_PAT_VAL  = 6'h01;
    localparam logic [5:0] IDX_PAT_CARE = 6'h02;
    localparam logic [5:0] IDX_STATUS   = 6'h03;
    localparam logic [5:0] IDX_IRQ_STAT = 6'h04;
    localparam logic [5:0] IDX_IRQ_CLR  = 6'h05;
    localparam logic [5:0] IDX_IRQ_EN   = 6'h06;

    // ------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_SWEEP_BIT = 2;
    localparam int CTRL_DLY_LSB   = 3;
    localparam int CTRL_DEF_BIT   = 5;
    localparam int QUAL_BIT       = WORD_W;

    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

    // ------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        WPR_CLK_RISE,
        WPR_CLK_FALL,
        WPR_CLK_NONE,
        WPR_CLK_RSVD
    } wpr_clk_mode_e;

    typedef enum logic [1:0] {
        WPR_DLY_OFF,
        WPR_DLY_START,
        WPR_DLY_COUNT,
        WPR_DLY_BOTH
    } wpr_dly_use_e;

    typedef enum logic {
        WPR_BUS_IDLE,
        WPR_BUS_ACK
    } wpr_bus_state_e;

    typedef struct packed {
        wpr_clk_mode_e     mode;
        logic              sweep_b;
        wpr_dly_use_e      dly_use;
        logic              defined;
        logic [WORD_W:0]   pat_val;
        logic [WORD_W:0]   pat_care;
    } wpr_cfg_s;

    typedef struct packed {
        logic match;
        logic event_pulse;
    } wpr_hit_s;

endpackage : wpr_pkg
`default_nettype wire

// [rtl/wpr_sync.sv]
`default_nettype none
module wpr_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk_i,
    input  wire logic         reset_n_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } wpr_sync_st_s;

    wpr_sync_st_s st;
    wpr_sync_st_s next_st;

    always_comb begin
        next_st    = st;
        next_st.s1 = async_i;
        next_st.s2 = st.s1;
        if (!reset_n_i) begin
            next_st = '0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        st <= next_st;
    end

    assign sync_o = st.s2;
endmodule : wpr_sync
`default_nettype wire

// [rtl/wpr_compare.sv]
`default_nettype none
module wpr_compare #(
    parameter int W = wpr_pkg::WORD_W + 1
) (
    input  wire logic [W-1:0] data_i,
    input  wire logic [W-1:0] val_i,
    input  wire logic [W-1:0] care_i,
    output logic              hit_o
);
    logic [W-1:0] bit_ok;

    // Don't-care bits always agree; the top bit is the qualifier
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            assign bit_ok[g] = ~care_i[g] | (data_i[g] ~^ val_i[g]);
        end
    endgenerate

    assign hit_o = &bit_ok;
endmodule : wpr_compare
`default_nettype wire

// [rtl/wpr_top.sv]
// Overview of operation
// - In synchronous mode the data word is sampled only on the selected rising or falling probe clock edge.
// - In the no-clock mode the word is compared continuously without waiting for any edge.
// - A qualifier bit is compared together with the data word.
// - Each pattern bit is zero, one or don't-care, and don't-care bits are left out of the comparison.
// - The match output is high while the selected word is recognized and low otherwise.
// - Once a pattern is defined the match output keeps working even when no function uses it.
// - The match output changes only after a latency from the clock edge or from the coincidence.
// - Configuration picks whether the first or the second sweep gets the recognition trigger.
// - The recognition event can be chosen as the delay start event or as the counted delay event.
`default_nettype none
module wpr_top (
    input  wire logic                        ref_clk_i,
    input  wire logic                        reset_n_i,
    // Avalon-MM slave
    input  wire logic [5:0]                  avs_address_i,
    input  wire logic                        avs_read_i,
    input  wire logic                        avs_write_i,
    input  wire logic [31:0]                 avs_writedata_i,
    input  wire logic [3:0]                  avs_byteenable_i,
    output logic      [31:0]                 avs_readdata_o,
    output logic                             avs_waitrequest_o,
    // Probed circuit
    input  wire logic [wpr_pkg::WORD_W-1:0]  probe_data_i,
    input  wire logic                        probe_qual_i,
    input  wire logic                        probe_clk_i,
    // Sweep and delay logic, and interrupt
    output logic                             word_match_o,
    output logic                             trig_sweep_a_o,
    output logic                             trig_sweep_b_o,
    output logic                             dly_start_o,
    output logic                             dly_count_o,
    output logic                             irq_o
);
    localparam int W = wpr_pkg::WORD_W + 1;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        wpr_pkg::wpr_cfg_s       cfg;
        wpr_pkg::wpr_bus_state_e bus;
        logic                    waitreq;
        logic [31:0]             rdata;
        logic                    clk_d;
        logic                    hit_q;
        logic                    match;
        logic                    trig_a;
        logic                    trig_b;
        logic                    dstart;
        logic                    dcount;
        logic [1:0]              irq_stat;
        logic [1:0]              irq_en;
        logic                    irq;
    } wpr_top_st_s;

    wpr_top_st_s st;
    wpr_top_st_s next_st;

    logic [W-1:0] probe_sync;
    logic         clk_sync;
    logic         hit_now;
    logic         rise_edge;
    logic         fall_edge;
    logic         sample;
    logic         next_hit;
    logic         wr_go;
    logic         req_go;
    logic         rd_go;
    logic [31:0]  wmask;

    // ------------------------------------------------------------
    // Input capture and compare
    // ------------------------------------------------------------
    wpr_sync #(
        .W (W + 1)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .reset_n_i (reset_n_i),
        .async_i   ({probe_clk_i, probe_qual_i, probe_data_i}),
        .sync_o    ({clk_sync, probe_sync})
    );

    wpr_compare #(
        .W (W)
    ) u_cmp (
        .data_i (probe_sync),
        .val_i  (st.cfg.pat_val),
        .care_i (st.cfg.pat_care),
        .hit_o  (hit_now)
    );

    function automatic logic [31:0] byte_mask(input logic [3:0] be);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{be[i]}};
        end
        return m;
    endfunction : byte_mask

    assign rise_edge = clk_sync & ~st.clk_d;
    assign fall_edge = ~clk_sync & st.clk_d;
    // Writes land on the answering edge, the one where the master sees waitrequest low
    assign wr_go     = avs_write_i & (st.bus == wpr_pkg::WPR_BUS_ACK);
    assign rd_go     = avs_read_i & (st.bus == wpr_pkg::WPR_BUS_IDLE);
    assign req_go    = (avs_read_i | avs_write_i) & (st.bus == wpr_pkg::WPR_BUS_IDLE);
    assign wmask     = byte_mask(avs_byteenable_i);

    // Sampling point follows the chosen edge; async mode samples every cycle
    always_comb begin
        case (st.cfg.mode)
            wpr_pkg::WPR_CLK_RISE: sample = rise_edge;
            wpr_pkg::WPR_CLK_FALL: sample = fall_edge;
            wpr_pkg::WPR_CLK_NONE: sample = 1'b1;
            default:               sample = 1'b0;
        endcase
    end

    // Hit is held between edges; the register stage is the output latency
    assign next_hit = sample ? hit_now : st.hit_q;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [31:0] ctrl_w;
        logic        new_event;
        ctrl_w    = '0;
        new_event = 1'b0;
        next_st   = st;

        next_st.clk_d = clk_sync;
        next_st.hit_q = next_hit;
        // Match is gated only by a pattern being defined, not by any function
        next_st.match = next_hit & st.cfg.defined;
        new_event     = next_st.match & ~st.match;
        next_st.trig_a = new_event & ~st.cfg.sweep_b;
        next_st.trig_b = new_event & st.cfg.sweep_b;
        next_st.dstart = new_event & st.cfg.dly_use[0];
        next_st.dcount = new_event & st.cfg.dly_use[1];

        // Bus: every access answers one cycle later
        next_st.bus = wpr_pkg::WPR_BUS_IDLE;
        if (req_go) begin
            next_st.bus = wpr_pkg::WPR_BUS_ACK;
        end
        next_st.waitreq = (next_st.bus == wpr_pkg::WPR_BUS_IDLE);

        if (wr_go) begin
            if (avs_address_i == wpr_pkg::IDX_CTRL) begin
                ctrl_w = ({26'h0, st.cfg.defined, st.cfg.dly_use, st.cfg.sweep_b, st.cfg.mode} & ~wmask)
                       | (avs_writedata_i & wmask);
                next_st.cfg.mode    = wpr_pkg::wpr_clk_mode_e'(ctrl_w[wpr_pkg::CTRL_MODE_LSB +: 2]);
                next_st.cfg.sweep_b = ctrl_w[wpr_pkg::CTRL_SWEEP_BIT];
                next_st.cfg.dly_use = wpr_pkg::wpr_dly_use_e'(ctrl_w[wpr_pkg::CTRL_DLY_LSB +: 2]);
            end else if (avs_address_i == wpr_pkg::IDX_PAT_VAL) begin
                next_st.cfg.pat_val = W'((32'(st.cfg.pat_val) & ~wmask) | (avs_writedata_i & wmask));
                next_st.cfg.defined = 1'b1;
            end else if (avs_address_i == wpr_pkg::IDX_PAT_CARE) begin
                next_st.cfg.pat_care = W'((32'(st.cfg.pat_care) & ~wmask) | (avs_writedata_i & wmask));
                next_st.cfg.defined  = 1'b1;
            end else if (avs_address_i == wpr_pkg::IDX_IRQ_EN) begin
                next_st.irq_en = avs_writedata_i[1:0];
            end
        end

        // Set wins over a clear in the same cycle
        if (wr_go && avs_address_i == wpr_pkg::IDX_IRQ_CLR) begin
            next_st.irq_stat = st.irq_stat & ~avs_writedata_i[1:0];
        end
        next_st.irq_stat = next_st.irq_stat | {~next_st.match & st.match, new_event};
        next_st.irq      = |(next_st.irq_stat & next_st.irq_en);

        if (rd_go) begin
            if (avs_address_i == wpr_pkg::IDX_CTRL) begin
                next_st.rdata = {26'h0, st.cfg.defined, st.cfg.dly_use, st.cfg.sweep_b, st.cfg.mode};
            end else if (avs_address_i == wpr_pkg::IDX_PAT_VAL) begin
                next_st.rdata = 32'(st.cfg.pat_val);
            end else if (avs_address_i == wpr_pkg::IDX_PAT_CARE) begin
                next_st.rdata = 32'(st.cfg.pat_care);
            end else if (avs_address_i == wpr_pkg::IDX_STATUS) begin
                next_st.rdata = {29'h0, st.cfg.defined, st.hit_q, st.match};
            end else if (avs_address_i == wpr_pkg::IDX_IRQ_STAT) begin
                next_st.rdata = {30'h0, st.irq_stat};
            end else if (avs_address_i == wpr_pkg::IDX_IRQ_EN) begin
                next_st.rdata = {30'h0, st.irq_en};
            end else begin
                next_st.rdata = wpr_pkg::RD_UNMAPPED;
            end
        end

        if (!reset_n_i) begin
            next_st          = '0;
            next_st.cfg.mode = wpr_pkg::WPR_CLK_RISE;
            next_st.waitreq  = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        st <= next_st;
    end

    assign avs_readdata_o    = st.rdata;
    assign avs_waitrequest_o = st.waitreq;
    assign word_match_o      = st.match;
    assign trig_sweep_a_o    = st.trig_a;
    assign trig_sweep_b_o    = st.trig_b;
    assign dly_start_o       = st.dstart;
    assign dly_count_o       = st.dcount;
    assign irq_o             = st.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    a_rise_only_sample: assert property (
        (st.cfg.mode == wpr_pkg::WPR_CLK_RISE) && !rise_edge && $stable(st.cfg) |=> $stable(st.hit_q))
        else $error("hit changed without rising edge");
    a_fall_only_sample: assert property (
        (st.cfg.mode == wpr_pkg::WPR_CLK_FALL) && !fall_edge && $stable(st.cfg) |=> $stable(st.hit_q))
        else $error("hit changed without falling edge");
    a_async_follow: assert property (
        (st.cfg.mode == wpr_pkg::WPR_CLK_NONE) |=> st.hit_q == $past(hit_now))
        else $error("async compare not followed");
    a_match_level: assert property (
        st.match |-> st.hit_q && st.cfg.defined)
        else $error("match without hit");
    a_match_kept: assert property (
        st.cfg.defined && $stable(st.cfg.defined) |-> st.match == st.hit_q)
        else $error("defined pattern not reflected");
    a_match_latency: assert property (
        sample && hit_now && st.cfg.defined |=> word_match_o)
        else $error("match not one cycle after sample");
    a_sweep_route: assert property (
        $rose(st.match) |-> (trig_sweep_b_o == $past(st.cfg.sweep_b)) && (trig_sweep_a_o == !$past(st.cfg.sweep_b)))
        else $error("trigger routed to wrong sweep");
    a_delay_route: assert property (
        $rose(st.match) |-> dly_count_o == $past(st.cfg.dly_use[1]) && dly_start_o == $past(st.cfg.dly_use[0])
            ##1 !dly_count_o && !dly_start_o)
        else $error("delay count event wrong");
    a_bus_answer: assert property (
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("bus did not answer in one cycle");

    c_sync_match: cover property (st.cfg.mode == wpr_pkg::WPR_CLK_RISE && $rose(st.match));
    c_fall_match: cover property (st.cfg.mode == wpr_pkg::WPR_CLK_FALL && $rose(st.match));
    c_async_match: cover property (st.cfg.mode == wpr_pkg::WPR_CLK_NONE && $rose(st.match));
    c_irq: cover property ($rose(irq_o));
endmodule : wpr_top
`default_nettype wire

// [dv/wpr_probe_model.sv]
`default_nettype none
module wpr_probe_model (
    output logic                       probe_clk_o,
    output logic [wpr_pkg::WORD_W-1:0] probe_data_o,
    output logic                       probe_qual_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        probe_clk_o  = 1'b0;
        probe_data_o = '0;
        probe_qual_o = 1'b0;
    end

    // ------------------------------------------------------------
    // Frames
    // ------------------------------------------------------------
    // The clock runs only inside a frame, 160 ns period, off the bench grid.
    // Word w_r stands around the rising edge, w_f around the falling edge.
    task automatic frame(input logic [16:0] w_r, input logic [16:0] w_f);
        #3 {probe_qual_o, probe_data_o} <= w_r;
        #40 probe_clk_o <= 1'b1;
        #40 {probe_qual_o, probe_data_o} <= w_f;
        #40 probe_clk_o <= 1'b0;
        // Hold time over: the lines no longer show the word
        #40 {probe_qual_o, probe_data_o} <= ~w_f;
    endtask : frame

    task automatic hold(input logic [16:0] w);
        {probe_qual_o, probe_data_o} <= w;
    endtask : hold
endmodule : wpr_probe_model
`default_nettype wire

// [dv/word_pattern_recognizer_bench.sv]
`default_nettype none
module word_pattern_recognizer_bench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [16:0] P = 17'h1a5c3;
    logic        ref_clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic [5:0]  avs_address_i = '0;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = '0;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic [15:0] probe_data_i;
    logic        probe_qual_i;
    logic        probe_clk_i;
    logic        word_match_o, trig_sweep_a_o, trig_sweep_b_o, dly_start_o, dly_count_o, irq_o;
    logic [3:0]  avs_byteenable_i = 4'hf;
    logic        clr_cnt = 1'b1;
    logic [3:0]  na, nb, ns, nc;
    int          failures = 0;
    int          cmp_count = 0;

    always #5 ref_clk_i = ~ref_clk_i;

    // Event pulses last one cycle, so they are counted rather than sampled
    always @(posedge ref_clk_i) begin
        if (clr_cnt) begin
            {na, nb, ns, nc} <= '0;
        end else begin
            na <= na + 4'(trig_sweep_a_o);
            nb <= nb + 4'(trig_sweep_b_o);
            ns <= ns + 4'(dly_start_o);
            nc <= nc + 4'(dly_count_o);
        end
    end

    wpr_top DUT (
        .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .probe_data_i(probe_data_i), .probe_qual_i(probe_qual_i), .probe_clk_i(probe_clk_i),
        .word_match_o(word_match_o), .trig_sweep_a_o(trig_sweep_a_o), .trig_sweep_b_o(trig_sweep_b_o),
        .dly_start_o(dly_start_o), .dly_count_o(dly_count_o), .irq_o(irq_o)
    );

    wpr_probe_model PRB (.probe_clk_o(probe_clk_i), .probe_data_o(probe_data_i), .probe_qual_o(probe_qual_i));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge ref_clk_i);
        avs_address_i   <= a;
        avs_writedata_i <= d;
        avs_write_i     <= wr;
        avs_read_i      <= !wr;
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk_i);
            if (avs_waitrequest_o === 1'b0) break;
        end
        if (n == 50) failures++;
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
    endtask : bus

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, '0, q);
        chk(q, e);
    endtask : rd

    // One probe frame, then the settled match level is compared
    task automatic fr_chk(input logic [16:0] r, input logic [16:0] f, input logic m);
        clr_cnt <= 1'b1;
        @(posedge ref_clk_i);
        clr_cnt <= 1'b0;
        PRB.frame(r, f);
        repeat (8) @(posedge ref_clk_i);
        chk(32'(word_match_o), 32'(m));
    endtask : fr_chk

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        #400000;
        failures++;
        stop_test();
    end

    initial begin
        repeat (12) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        chk({irq_o, word_match_o, avs_waitrequest_o}, 32'h1);
        rd(wpr_pkg::IDX_CTRL, 32'h0);
        wr(wpr_pkg::IDX_CTRL, 32'h1f);
        rd(wpr_pkg::IDX_CTRL, 32'h1f);
        avs_byteenable_i <= 4'h0;
        wr(wpr_pkg::IDX_CTRL, 32'h0);
        rd(wpr_pkg::IDX_CTRL, 32'h1f);
        avs_byteenable_i <= 4'hf;
        wr(6'h2a, 32'hffff_ffff);
        rd(6'h2a, 32'h0);
        wr(wpr_pkg::IDX_CTRL, 32'h0);
        fr_chk(P, P, 1'b0);
        wr(wpr_pkg::IDX_PAT_VAL, 32'(P));
        wr(wpr_pkg::IDX_PAT_CARE, 32'h1ffff);
        rd(wpr_pkg::IDX_PAT_VAL, 32'(P));
        rd(wpr_pkg::IDX_CTRL, 32'h20);
        for (int m = 0; m < 2; m++) begin
            wr(wpr_pkg::IDX_CTRL, 32'(m));
            fr_chk(P, ~P, m == 0);
            fr_chk(~P, P, m == 1);
        end
        chk({na, nb}, 32'h10);
        fr_chk(P ^ 17'h10000, P ^ 17'h10000, 1'b0);
        wr(wpr_pkg::IDX_PAT_CARE, 32'h0ff0f);
        fr_chk(P ^ 17'h100f0, P ^ 17'h100f0, 1'b1);
        fr_chk(P ^ 17'h00100, P ^ 17'h00100, 1'b0);
        wr(wpr_pkg::IDX_PAT_CARE, 32'h1ffff);
        for (int i = 0; i < 8; i++) begin
            wr(wpr_pkg::IDX_CTRL, 32'(i << 2));
            fr_chk(~P, ~P, 1'b0);
            fr_chk(P, P, 1'b1);
            chk({na, nb, ns, nc}, {4'(!i[0]), 4'(i[0]), 4'(i[1]), 4'(i[2])});
        end
        wr(wpr_pkg::IDX_CTRL, 32'h3);
        fr_chk(~P, ~P, 1'b1);
        wr(wpr_pkg::IDX_CTRL, 32'h0);
        rd(wpr_pkg::IDX_STATUS, 32'h7);
        wr(wpr_pkg::IDX_IRQ_CLR, 32'h3);
        wr(wpr_pkg::IDX_IRQ_EN, 32'h0);
        fr_chk(~P, ~P, 1'b0);
        fr_chk(P, P, 1'b1);
        chk(32'(irq_o), 32'h0);
        rd(wpr_pkg::IDX_IRQ_STAT, 32'h3);
        wr(wpr_pkg::IDX_IRQ_EN, 32'h1);
        repeat (3) @(posedge ref_clk_i);
        chk(32'(irq_o), 32'h1);
        wr(wpr_pkg::IDX_IRQ_CLR, 32'h1);
        repeat (3) @(posedge ref_clk_i);
        chk(32'(irq_o), 32'h0);
        rd(wpr_pkg::IDX_IRQ_STAT, 32'h2);
        wr(wpr_pkg::IDX_CTRL, 32'h2);
        PRB.hold(~P);
        repeat (8) @(posedge ref_clk_i);
        chk(32'(word_match_o), 32'h0);
        PRB.hold(P);
        @(posedge ref_clk_i);
        chk(32'(word_match_o), 32'h0);
        repeat (8) @(posedge ref_clk_i);
        chk(32'(word_match_o), 32'h1);
        PRB.hold(~P);
        repeat (8) @(posedge ref_clk_i);
        chk(32'(word_match_o), 32'h0);
        stop_test();
    end
endmodule : word_pattern_recognizer_bench
`default_nettype wire
